/* inc/pmicls_pkg.sv */
/*
 * Shared constants and types of the live status register bank.
 * Assumes a single register-interface clock and that the serial register
 * interface in front of it delivers decoded read and write strobes.
 */
// Contract
// - Top status bit 3 reads one while the external sync clock frequency is invalid and zero while valid.
// - Top status bit 2 reads one while the die is above the thermal shutdown level and zero otherwise.
// - Top status bit 1 reads one while the die is above the thermal warning level and zero otherwise.
// - Top status bit 0 reads one while the input supply is above the overvoltage threshold and zero otherwise.
// - Step-down status bit 7 shows whether converter B is enabled.
// - Step-down status bit 6 shows whether converter B output is valid.
// - Step-down status bit 4 reads one while converter B sits at its current limit.
// - Step-down status bit 3 shows whether converter A is enabled.
// - Step-down status bit 2 shows the raw output validity of converter A.
// - Step-down status bit 0 reads one while converter A sits at its current limit.
// - Boost status bit 3 shows whether the boost converter is enabled.
// - Boost status bit 2 shows the raw output validity of the boost converter.
// - Boost status bit 0 reads one while the boost converter sits at its current limit.

package pmicls_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_TOP_LIVE_STATUS = 8'h25;
    localparam logic [ADDR_W-1:0] OFS_STEPDOWN_LIVE_STATUS = 8'h26;
    localparam logic [ADDR_W-1:0] OFS_BOOST_LIVE_STATUS = 8'h27;

    // Reset value of every register and of unmapped reads.
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // Top status field positions.
    localparam int TOP_SYNC_CLK_INVALID = 3;
    localparam int TOP_THERMAL_SHUTDOWN = 2;
    localparam int TOP_THERMAL_WARNING = 1;
    localparam int TOP_INPUT_OVERVOLTAGE = 0;

    // Step-down status field positions.
    localparam int SD_B_ENABLED = 7;
    localparam int SD_B_OUTPUT_GOOD = 6;
    localparam int SD_B_CURRENT_LIMIT = 4;
    localparam int SD_A_ENABLED = 3;
    localparam int SD_A_OUTPUT_GOOD = 2;
    localparam int SD_A_CURRENT_LIMIT = 0;

    // Boost status field positions.
    localparam int SU_ENABLED = 3;
    localparam int SU_OUTPUT_GOOD = 2;
    localparam int SU_CURRENT_LIMIT = 0;

    // Masks of the bits that carry a field; every other bit is reserved and reads zero.
    localparam logic [DATA_W-1:0] TOP_USED = 8'h0f;
    localparam logic [DATA_W-1:0] SD_USED = 8'hdd;
    localparam logic [DATA_W-1:0] SU_USED = 8'h0d;

    // Raw analog conditions, as they arrive from the detectors.
    typedef struct packed {
        logic sync_clk_invalid;
        logic thermal_shutdown_flag;
        logic thermal_warning_flag;
        logic input_overvoltage_flag;
        logic stepdown_b_enabled;
        logic stepdown_b_output_good;
        logic stepdown_b_at_current_limit;
        logic stepdown_a_enabled;
        logic stepdown_a_output_good;
        logic stepdown_a_at_current_limit;
        logic stepup_enabled;
        logic stepup_output_good;
        logic stepup_at_current_limit;
    } pmicls_cond_t;

    localparam int COND_W = $bits(pmicls_cond_t);

    // Register access strobes from the serial interface.
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [ADDR_W-1:0] addr;
    } pmicls_req_t;

endpackage

/* logic/pmicls_sync.sv */
/*
 * Three-stage synchroniser with an agreement filter for a vector of
 * asynchronous condition inputs.
 * Assumes each input is a level from analog detectors outside the clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module pmicls_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] filt
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // The chain of three flip-flops; only stage2 reads stage1.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (ce) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            filt <= '0;
        end else if (ce) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    filt[i] <= stage3[i];
                end
            end
        end
    end

endmodule // pmicls_sync

`default_nettype wire

/* logic/pmicls_top.sv */
/*
 * Live status register bank: three read-only registers that mirror the
 * present converter, thermal, overvoltage and sync clock conditions.
 * Assumes the serial register interface decodes transfers into one-cycle
 * read and write strobes with an address, on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pmicls_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire pmicls_pkg::pmicls_cond_t cond_in,
    input wire pmicls_pkg::pmicls_req_t req,
    output logic [pmicls_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic wr_refused,
    output logic [pmicls_pkg::DATA_W-1:0] top_live_status,
    output logic [pmicls_pkg::DATA_W-1:0] stepdown_live_status,
    output logic [pmicls_pkg::DATA_W-1:0] boost_live_status
);
    import pmicls_pkg::*;

    logic [COND_W-1:0] filt_vec;
    pmicls_cond_t filt;

    // Builds the top status byte from the filtered conditions.
    function automatic logic [DATA_W-1:0] pack_top(input pmicls_cond_t c);
        logic [DATA_W-1:0] v;
        v = REG_RESET;
        v[TOP_SYNC_CLK_INVALID] = c.sync_clk_invalid;
        v[TOP_THERMAL_SHUTDOWN] = c.thermal_shutdown_flag;
        v[TOP_THERMAL_WARNING] = c.thermal_warning_flag;
        v[TOP_INPUT_OVERVOLTAGE] = c.input_overvoltage_flag;
        return v;
    endfunction

    // Builds the step-down status byte.
    function automatic logic [DATA_W-1:0] pack_sd(input pmicls_cond_t c);
        logic [DATA_W-1:0] v;
        v = REG_RESET;
        v[SD_B_ENABLED] = c.stepdown_b_enabled;
        v[SD_B_OUTPUT_GOOD] = c.stepdown_b_output_good;
        v[SD_B_CURRENT_LIMIT] = c.stepdown_b_at_current_limit;
        v[SD_A_ENABLED] = c.stepdown_a_enabled;
        v[SD_A_OUTPUT_GOOD] = c.stepdown_a_output_good;
        v[SD_A_CURRENT_LIMIT] = c.stepdown_a_at_current_limit;
        return v;
    endfunction

    // Builds the boost status byte.
    function automatic logic [DATA_W-1:0] pack_su(input pmicls_cond_t c);
        logic [DATA_W-1:0] v;
        v = REG_RESET;
        v[SU_ENABLED] = c.stepup_enabled;
        v[SU_OUTPUT_GOOD] = c.stepup_output_good;
        v[SU_CURRENT_LIMIT] = c.stepup_at_current_limit;
        return v;
    endfunction

    // Selects the register at an offset; unmapped offsets read as reset value.
    function automatic logic [DATA_W-1:0] reg_lookup(
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] t,
        input logic [DATA_W-1:0] s,
        input logic [DATA_W-1:0] b
    );
        logic [DATA_W-1:0] v;
        v = REG_RESET;
        case (a)
            OFS_TOP_LIVE_STATUS: v = t;
            OFS_STEPDOWN_LIVE_STATUS: v = s;
            OFS_BOOST_LIVE_STATUS: v = b;
            default: v = REG_RESET;
        endcase
        return v;
    endfunction

    // Bring the detector levels into the register clock domain.
    pmicls_sync #(
        .WIDTH(COND_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .async_in(cond_in),
        .filt(filt_vec)
    );

    assign filt = pmicls_cond_t'(filt_vec);

    // Status registers follow the filtered conditions every enabled cycle, no latching.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            top_live_status <= REG_RESET;
            stepdown_live_status <= REG_RESET;
            boost_live_status <= REG_RESET;
        end else if (ce) begin
            top_live_status <= pack_top(filt);
            stepdown_live_status <= pack_sd(filt);
            boost_live_status <= pack_su(filt);
        end
    end

    // Read port: data and valid one cycle after the strobe.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_data <= REG_RESET;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= req.rd_en;
            if (req.rd_en) begin
                rd_data <= reg_lookup(req.addr, top_live_status, stepdown_live_status, boost_live_status);
            end
        end
    end

    // Writes are acknowledged as refused and never reach the registers.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_refused <= 1'b0;
        end else if (ce) begin
            wr_refused <= req.wr_en;
        end
    end

    default clocking dflt_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // Top status bits mirror their filtered conditions one enabled cycle later.
    sync_clk_bit_a: assert property (
        ce |=> top_live_status[TOP_SYNC_CLK_INVALID] == $past(filt.sync_clk_invalid))
        else $error("Sync clock status bit does not follow its condition.");

    shutdown_bit_a: assert property (
        ce |=> top_live_status[TOP_THERMAL_SHUTDOWN] == $past(filt.thermal_shutdown_flag))
        else $error("Thermal shutdown bit does not follow its condition.");

    warning_bit_a: assert property (
        ce |=> top_live_status[TOP_THERMAL_WARNING] == $past(filt.thermal_warning_flag))
        else $error("Thermal warning bit does not follow its condition.");

    overvolt_bit_a: assert property (
        ce |=> top_live_status[TOP_INPUT_OVERVOLTAGE] == $past(filt.input_overvoltage_flag))
        else $error("Overvoltage bit does not follow its condition.");

    // Step-down status bits mirror both converters one enabled cycle later.
    sd_b_enable_a: assert property (
        ce |=> stepdown_live_status[SD_B_ENABLED] == $past(filt.stepdown_b_enabled))
        else $error("Converter B enable bit is wrong.");

    sd_b_good_a: assert property (
        ce |=> stepdown_live_status[SD_B_OUTPUT_GOOD] == $past(filt.stepdown_b_output_good))
        else $error("Converter B output good bit is wrong.");

    sd_b_limit_a: assert property (
        ce |=> stepdown_live_status[SD_B_CURRENT_LIMIT] == $past(filt.stepdown_b_at_current_limit))
        else $error("Converter B current limit bit is wrong.");

    sd_a_enable_a: assert property (
        ce |=> stepdown_live_status[SD_A_ENABLED] == $past(filt.stepdown_a_enabled))
        else $error("Converter A enable bit is wrong.");

    sd_a_good_a: assert property (
        ce |=> stepdown_live_status[SD_A_OUTPUT_GOOD] == $past(filt.stepdown_a_output_good))
        else $error("Converter A output good bit is wrong.");

    sd_a_limit_a: assert property (
        ce |=> stepdown_live_status[SD_A_CURRENT_LIMIT] == $past(filt.stepdown_a_at_current_limit))
        else $error("Converter A current limit bit is wrong.");

    // Boost status bits mirror the boost converter one enabled cycle later.
    su_enable_a: assert property (
        ce |=> boost_live_status[SU_ENABLED] == $past(filt.stepup_enabled))
        else $error("Boost enable bit is wrong.");

    su_good_a: assert property (
        ce |=> boost_live_status[SU_OUTPUT_GOOD] == $past(filt.stepup_output_good))
        else $error("Boost output good bit is wrong.");

    su_limit_a: assert property (
        ce |=> boost_live_status[SU_CURRENT_LIMIT] == $past(filt.stepup_at_current_limit))
        else $error("Boost current limit bit is wrong.");

    // Reserved bits stay zero and writes leave the registers alone.
    reserved_zero_a: assert property (((top_live_status & ~TOP_USED) == REG_RESET)
        && ((stepdown_live_status & ~SD_USED) == REG_RESET)
        && ((boost_live_status & ~SU_USED) == REG_RESET))
        else $error("A reserved status bit reads one.");

    write_ignored_a: assert property (ce && req.wr_en && !req.rd_en ##1 ce && $stable(filt_vec)
        |=> $stable(top_live_status) && $stable(stepdown_live_status) && $stable(boost_live_status))
        else $error("A write disturbed the status registers.");

    refuse_pulse_a: assert property (ce |=> wr_refused == $past(req.wr_en))
        else $error("Write refusal pulse does not match the write strobe.");

    unmapped_zero_a: assert property (ce && req.rd_en
        && req.addr != OFS_TOP_LIVE_STATUS && req.addr != OFS_STEPDOWN_LIVE_STATUS
        && req.addr != OFS_BOOST_LIVE_STATUS |=> rd_data == REG_RESET)
        else $error("An unmapped offset did not read zero.");

    // A read returns the register as it stood when the strobe was taken.
    read_path_a: assert property (ce && req.rd_en |=> rd_valid
        && rd_data == reg_lookup($past(req.addr), $past(top_live_status),
        $past(stepdown_live_status), $past(boost_live_status)))
        else $error("Read data does not match the live register.");

    top_read_a: assert property (ce && req.rd_en && req.addr == OFS_TOP_LIVE_STATUS
        |=> rd_data == $past(top_live_status))
        else $error("Top status read returned wrong data.");

    sd_read_a: assert property (ce && req.rd_en && req.addr == OFS_STEPDOWN_LIVE_STATUS
        |=> rd_data == $past(stepdown_live_status))
        else $error("Step-down status read returned wrong data.");

    su_read_a: assert property (ce && req.rd_en && req.addr == OFS_BOOST_LIVE_STATUS
        |=> rd_data == $past(boost_live_status))
        else $error("Boost status read returned wrong data.");

    read_pulse_a: assert property (ce && !req.rd_en |=> !rd_valid && $stable(rd_data))
        else $error("Read data moved or was marked fresh without a read.");

    // With the enable low every flop of the bank holds its value.
    enable_freeze_a: assert property (!ce
        |=> $stable(top_live_status) && $stable(stepdown_live_status) && $stable(boost_live_status)
        && $stable(rd_data) && $stable(rd_valid) && $stable(wr_refused))
        else $error("State moved while the clock enable was low.");

endmodule // pmicls_top

`default_nettype wire

/* bench/pmicls_host.sv */
/*
 * Host-side model of the live status register bank: it issues single-cycle
 * read and write strobes and collects the answer one cycle later.
 * Assumes the bank takes a strobe on a rising clk_sys edge with ce high.
 */
`timescale 1ns/100ps
`default_nettype none

module pmicls_host (
    input wire logic clk_sys,
    input wire logic rd_valid,
    input wire logic wr_refused,
    input wire logic [pmicls_pkg::DATA_W-1:0] rd_data,
    output var pmicls_pkg::pmicls_req_t req
);
    import pmicls_pkg::*;

    // The host starts idle, with no strobe raised.
    initial req = '0;

    // One read: strobe for one cycle, then take data while rd_valid stands.
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
        @(posedge clk_sys);
        req <= '{rd_en: 1'b1, wr_en: 1'b0, addr: a};
        @(posedge clk_sys);
        req <= '0;
        #1;
        ok = rd_valid;
        d = rd_data;
    endtask

    // One write: the bank never stores it and answers with a refusal pulse.
    task automatic wr_reg(input logic [ADDR_W-1:0] a, output logic ok);
        @(posedge clk_sys);
        req <= '{rd_en: 1'b0, wr_en: 1'b1, addr: a};
        @(posedge clk_sys);
        req <= '0;
        #1;
        ok = wr_refused;
    endtask

    // Read and write strobes in one cycle: the read answers and the write is refused.
    task automatic rdwr_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
        @(posedge clk_sys);
        req <= '{rd_en: 1'b1, wr_en: 1'b1, addr: a};
        @(posedge clk_sys);
        req <= '0;
        #1;
        ok = rd_valid && wr_refused;
        d = rd_data;
    endtask
endmodule // pmicls_host

`default_nettype wire

/* bench/pmicls_top_tb_top.sv */
/*
 * Self-checking testbench of the live status register bank.
 * Assumes the host model in pmicls_host.sv and a 10 MHz register clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pmicls_top_tb_top;
    import pmicls_pkg::*;

    logic clk_sys;
    logic rst_b;
    logic ce;
    pmicls_cond_t cond_in;
    pmicls_req_t req;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic wr_refused;
    logic [DATA_W-1:0] top_s;
    logic [DATA_W-1:0] sd_s;
    logic [DATA_W-1:0] su_s;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    pmicls_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .cond_in(cond_in), .req(req),
        .rd_data(rd_data), .rd_valid(rd_valid), .wr_refused(wr_refused), .top_live_status(top_s),
        .stepdown_live_status(sd_s), .boost_live_status(su_s));

    pmicls_host host_u (.clk_sys(clk_sys), .rd_valid(rd_valid), .wr_refused(wr_refused),
        .rd_data(rd_data), .req(req));

    // Expected register images, built from the documented bit positions.
    function automatic logic [DATA_W-1:0] exp_top(input pmicls_cond_t c);
        return {4'h0, c.sync_clk_invalid, c.thermal_shutdown_flag, c.thermal_warning_flag, c.input_overvoltage_flag};
    endfunction
    function automatic logic [DATA_W-1:0] exp_sd(input pmicls_cond_t c);
        return {c.stepdown_b_enabled, c.stepdown_b_output_good, 1'b0, c.stepdown_b_at_current_limit,
            c.stepdown_a_enabled, c.stepdown_a_output_good, 1'b0, c.stepdown_a_at_current_limit};
    endfunction
    function automatic logic [DATA_W-1:0] exp_su(input pmicls_cond_t c);
        return {4'h0, c.stepup_enabled, c.stepup_output_good, 1'b0, c.stepup_at_current_limit};
    endfunction

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Reads one register through the host and checks the answer pulse and data.
    task automatic check_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        logic ok;
        host_u.rd_reg(a, d, ok);
        check({6'h00, wr_refused, ok}, 8'h01);
        check(d, exp);
    endtask

    // Checks all three registers by read and at their ports, plus an unmapped read.
    task automatic check_all(input pmicls_cond_t c);
        check_reg(OFS_TOP_LIVE_STATUS, exp_top(c));
        check_reg(OFS_STEPDOWN_LIVE_STATUS, exp_sd(c));
        check_reg(OFS_BOOST_LIVE_STATUS, exp_su(c));
        check_reg(8'h28, 8'h00);
        check(top_s, exp_top(c));
        check(sd_s, exp_sd(c));
        check(su_s, exp_su(c));
    endtask

    // Applies a condition set and lets the synchroniser path settle.
    task automatic set_cond(input pmicls_cond_t c);
        @(posedge clk_sys);
        cond_in <= c;
        repeat (6) @(posedge clk_sys);
    endtask

    // Free-running register clock, 100 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            final_report();
        end
    end

    // Main sequence.
    initial begin
        logic ok;
        logic [DATA_W-1:0] d;
        pmicls_cond_t c;
        rst_b = 1'b0;
        ce = 1'b1;
        cond_in = '0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        check_all('0);
        // One condition at a time, then cleared, shows no latching.
        for (int i = 0; i < COND_W; i++) begin
            c = pmicls_cond_t'(13'h0001 << i);
            set_cond(c);
            check_all(c);
            set_cond('0);
            check_all('0);
        end
        // A one-cycle spike on every detector is filtered out before the registers.
        @(posedge clk_sys);
        cond_in <= '1;
        @(posedge clk_sys);
        cond_in <= '0;
        repeat (6) @(posedge clk_sys);
        check_all('0);
        // With ce low nothing moves; once ce returns, every bit shows.
        @(posedge clk_sys);
        ce <= 1'b0;
        cond_in <= '1;
        repeat (10) @(posedge clk_sys);
        #1;
        check(top_s, 8'h00);
        check(sd_s, 8'h00);
        check(su_s, 8'h00);
        @(posedge clk_sys);
        ce <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check_all('1);
        // Writes to every register and to an unmapped place are refused.
        for (int i = 0; i < 4; i++) begin
            host_u.wr_reg(8'(OFS_TOP_LIVE_STATUS + i), ok);
            check({6'h00, rd_valid, ok}, 8'h01);
        end
        check_all('1);
        // A read and a write in one cycle both act; the read still returns live data.
        host_u.rdwr_reg(OFS_STEPDOWN_LIVE_STATUS, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp_sd('1));
        // A reset in mid-run clears every register; afterwards they follow the conditions again.
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check(top_s, REG_RESET);
        check(sd_s, REG_RESET);
        check(su_s, REG_RESET);
        check({6'h00, rd_valid, wr_refused}, 8'h00);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check_all('1);
        final_report();
    end
endmodule // pmicls_top_tb_top

`default_nettype wire
